// ### src/mrc_reset_ctrl.sv
`timescale 1ns/1ps
`include "mrc_params.svh"
module mrc_reset_ctrl #(
	parameter int POR_CYCLES = `MRC_POR_CYCLES
) (
	input  wire logic                   pclk,
	input  wire logic                   presetn,
	input  wire logic                   clk_en,
	input  wire logic                   supply_good,
	input  wire logic                   supply_low,
	input  wire logic                   rst_pin_in,
	output logic                        rst_pin_out,
	output logic                        rst_pin_oe_n,
	output logic                        sys_rst_n,
	output mrc_pkg::mrc_core_ctl_t      core_ctl,
	output logic                        supply_mon_en,
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [11:0]            paddr,
	input  wire logic [31:0]            pwdata,
	output logic [31:0]                 prdata,
	output logic                        pready,
	output logic                        pslverr,
	output logic                        irq
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	mrc_pkg::mrc_state_t state_q;
	logic [31:0]         cnt_q;
	logic                pin_sync;
	logic                sup_good_s;
	logic                sup_low_s;
	logic                rel_q;
	logic                cause_por_q;
	logic                cause_pin_q;
	logic                cause_sup_q;
	logic                cause_swr_q;
	logic                pend_por_q;
	logic                pend_pin_q;
	logic                pend_sup_q;
	logic                vdm_en_q;
	logic                sup_sel_q;
	logic [3:0]          istat_q;
	logic [3:0]          imask_q;
	logic                wr;
	logic                rd;
	logic                sw_por;
	logic                ext_rst;
	logic                sup_rst;
	logic                reset_req;
	logic                leave;
	logic                hit;
	logic [2:0]          echo_q;

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	mrc_sync3 #(.RST_VAL(1'b0)) u_sync_pin (
		.pclk    (pclk),
		.presetn (presetn),
		.en      (clk_en),
		.din     (rst_pin_in),
		.dout    (pin_sync)
	);
	mrc_sync3 #(.RST_VAL(1'b0)) u_sync_good (
		.pclk    (pclk),
		.presetn (presetn),
		.en      (clk_en),
		.din     (supply_good),
		.dout    (sup_good_s)
	);
	mrc_sync3 #(.RST_VAL(1'b0)) u_sync_low (
		.pclk    (pclk),
		.presetn (presetn),
		.en      (clk_en),
		.din     (supply_low),
		.dout    (sup_low_s)
	);

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	assign pready  = 1'b1;
	assign wr      = psel & penable & pwrite;
	assign rd      = psel & penable & ~pwrite;
	assign hit     = (paddr == `MRC_OFF_CAUSE) || (paddr == `MRC_OFF_CTRL) ||
	                 (paddr == `MRC_OFF_IRQ_STAT) || (paddr == `MRC_OFF_IRQ_MASK);
	assign pslverr = psel & penable & ~hit;
	// software power-on request via pin flag write
	assign sw_por  = clk_en & wr & (paddr == `MRC_OFF_CAUSE) & pwdata[`MRC_BIT_PIN];
	// own drive on the pin is ignored until its echo leaves the synchroniser
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			echo_q <= `MRC_PIN_ECHO_CYCLES;
		end else if (clk_en) begin
			if (!rst_pin_oe_n)
				echo_q <= `MRC_PIN_ECHO_CYCLES;
			else if (echo_q != 3'h0)
				echo_q <= echo_q - 3'h1;
		end
	end
	// only an outside pull on the pin counts as pin reset
	assign ext_rst = ~pin_sync & (echo_q == 3'h0);
	assign sup_rst = sup_low_s & vdm_en_q & sup_sel_q;
	assign reset_req = ext_rst | sup_rst | sw_por | ~sup_good_s;

	// read mux
	always_comb begin
		prdata = 32'h0000_0000;
		case (paddr)
			`MRC_OFF_CAUSE: begin
				prdata[`MRC_BIT_PIN] = cause_pin_q;
				prdata[`MRC_BIT_POR] = cause_por_q;
				prdata[`MRC_BIT_SUP] = cause_sup_q;
				prdata[`MRC_BIT_SWR] = cause_swr_q;
			end
			`MRC_OFF_CTRL: begin
				prdata[`MRC_BIT_MON_EN] = vdm_en_q;
				prdata[`MRC_BIT_SUPSEL] = sup_sel_q;
				prdata[7]               = sup_good_s;
			end
			`MRC_OFF_IRQ_STAT: prdata[3:0] = istat_q;
			`MRC_OFF_IRQ_MASK: prdata[3:0] = imask_q;
			default: prdata = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	assign leave = (state_q == mrc_pkg::MRC_ST_SYNC);

	// hold until supply good, then count release delay
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= mrc_pkg::MRC_ST_HOLD;
			cnt_q   <= 32'h0000_0000;
		end else if (clk_en) begin
			case (state_q)
				mrc_pkg::MRC_ST_HOLD: begin
					cnt_q <= 32'h0000_0000;
					if (sup_good_s && !ext_rst && !sup_rst && !pend_por_q)
						state_q <= mrc_pkg::MRC_ST_DELAY;
				end
				mrc_pkg::MRC_ST_DELAY: begin
					if (!sup_good_s || ext_rst) begin
						state_q <= mrc_pkg::MRC_ST_HOLD;
					end else if (cnt_q >= 32'(POR_CYCLES - 1)) begin
						state_q <= mrc_pkg::MRC_ST_SYNC;
					end else begin
						cnt_q <= cnt_q + 32'h0000_0001;
					end
				end
				mrc_pkg::MRC_ST_SYNC: state_q <= mrc_pkg::MRC_ST_RUN;
				mrc_pkg::MRC_ST_RUN: begin
					if (reset_req || !sup_good_s)
						state_q <= mrc_pkg::MRC_ST_HOLD;
				end
				default: state_q <= mrc_pkg::MRC_ST_HOLD;
			endcase
		end
	end

	// pending power-on: software request restarts full power-up path
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_por_q <= 1'b1;
		end else if (clk_en) begin
			if (sw_por || !sup_good_s)
				pend_por_q <= 1'b1;
			else if (state_q == mrc_pkg::MRC_ST_HOLD)
				pend_por_q <= 1'b0;
			else if (leave)
				pend_por_q <= 1'b0;
		end
	end

	// remember which source caused the current reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_pin_q <= 1'b0;
			pend_sup_q <= 1'b0;
			rel_q      <= 1'b1;
		end else if (clk_en) begin
			if (!sup_good_s) begin
				pend_pin_q <= 1'b0;
				pend_sup_q <= 1'b0;
				rel_q      <= 1'b1;
			end else if (state_q == mrc_pkg::MRC_ST_RUN && reset_req) begin
				pend_pin_q <= ext_rst & ~sw_por;
				pend_sup_q <= sup_rst & ~sw_por;
				rel_q      <= sw_por;
			end else if (leave) begin
				rel_q      <= 1'b0;
			end
		end
	end

	// internal reset: async assert, sync release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sys_rst_n <= 1'b0;
		else if (clk_en)
			sys_rst_n <= (state_q == mrc_pkg::MRC_ST_RUN) && !reset_req;
	end

	// pin driven low for power-on and supply resets
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_pin_oe_n <= 1'b0;
		end else if (clk_en) begin
			if (state_q == mrc_pkg::MRC_ST_RUN)
				rst_pin_oe_n <= ~(sup_rst | ~sup_good_s);
			else if (pend_sup_q || rel_q || !sup_good_s)
				rst_pin_oe_n <= 1'b0;
		end
	end
	assign rst_pin_out = 1'b0;

	// ----------------------------------------
	// cause flags
	// ----------------------------------------
	// flags updated on exit from reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cause_por_q <= 1'b0;
			cause_pin_q <= 1'b0;
			cause_sup_q <= 1'b0;
			cause_swr_q <= 1'b0;
		end else if (clk_en && leave) begin
			cause_por_q <= rel_q;
			cause_pin_q <= pend_pin_q & ~rel_q;
			cause_sup_q <= pend_sup_q & ~rel_q;
			cause_swr_q <= 1'b0;
		end
	end

	// supply monitor enabled on every power-on reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vdm_en_q  <= 1'b1;
			sup_sel_q <= 1'b0;
		end else if (clk_en) begin
			if (rel_q && leave) begin
				vdm_en_q  <= 1'b1;
				sup_sel_q <= 1'b0;
			end else if (wr && paddr == `MRC_OFF_CTRL) begin
				vdm_en_q  <= pwdata[`MRC_BIT_MON_EN];
				sup_sel_q <= pwdata[`MRC_BIT_SUPSEL];
			end
		end
	end
	assign supply_mon_en = vdm_en_q;

	// ----------------------------------------
	// interrupts: sticky, read clears, set wins
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			istat_q <= 4'h0;
		end else if (clk_en) begin
			istat_q <= (rd && paddr == `MRC_OFF_IRQ_STAT) ? 4'h0 : istat_q;
			if (leave)
				istat_q <= (rd && paddr == `MRC_OFF_IRQ_STAT ? 4'h0 : istat_q) |
				           {1'b0, pend_sup_q & ~rel_q, rel_q, pend_pin_q & ~rel_q};
		end
	end

	// mask register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			imask_q <= 4'h0;
		else if (clk_en && wr && paddr == `MRC_OFF_IRQ_MASK)
			imask_q <= pwdata[3:0];
	end
	assign irq = |(istat_q & imask_q);

	// ----------------------------------------
	// core defaults while in reset
	// ----------------------------------------
	// halt, defaults, no irq/timers ram kept, sp reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_ctl.core_run         <= 1'b0;
			core_ctl.irq_timer_en     <= 1'b0;
			core_ctl.stack_ptr        <= `MRC_SP_RESET;
			core_ctl.program_counter  <= `MRC_PROG_CNT_RESET;
			core_ctl.clk_sel_internal <= 1'b1;
			core_ctl.wdt_en           <= 1'b1;
			core_ctl.wdt_div          <= `MRC_WDT_DIV;
			core_ctl.port_latch       <= `MRC_PORT_RESET;
			core_ctl.port_open_drain  <= 1'b1;
			core_ctl.weak_pullup_en   <= 1'b1;
		end else if (clk_en) begin
			core_ctl.core_run        <= (state_q == mrc_pkg::MRC_ST_RUN) && !reset_req;
			core_ctl.irq_timer_en    <= 1'b0;
			core_ctl.weak_pullup_en  <= 1'b1;
			if (state_q != mrc_pkg::MRC_ST_RUN || reset_req) begin
				core_ctl.stack_ptr        <= `MRC_SP_RESET;
				core_ctl.program_counter  <= `MRC_PROG_CNT_RESET;
				core_ctl.clk_sel_internal <= 1'b1;
				core_ctl.wdt_en           <= 1'b1;
				core_ctl.wdt_div          <= `MRC_WDT_DIV;
				core_ctl.port_latch       <= `MRC_PORT_RESET;
				core_ctl.port_open_drain  <= 1'b1;
			end
		end
	end
endmodule : mrc_reset_ctrl

// ### src/mrc_params.svh
`ifndef MRC_PARAMS_SVH
`define MRC_PARAMS_SVH
// Notes on behaviour
// - reset halts core, loads defaults, disables irq
// - ram untouched, stack pointer reinitialised
// - port latches all ones, open drain, pullups
// - pin driven low through power and monitor resets
// - program counter cleared, internal oscillator selected
// - watchdog enabled, clock divided by twelve
// - execution restarts at address zero
// - hold until supply good, then release delay
// - power-on flag set after power-on reset
// - power-on flag cleared by other resets
// - supply monitor enabled by power-on reset
// - writing pin flag one forces power-on reset
// - pin flag set after external pin reset

// ----------------------------------------
// register offsets
// ----------------------------------------
`define MRC_OFF_CAUSE     12'h000
`define MRC_OFF_CTRL      12'h004
`define MRC_OFF_IRQ_STAT  12'h008
`define MRC_OFF_IRQ_MASK  12'h00c

// ----------------------------------------
// field positions
// ----------------------------------------
`define MRC_BIT_PIN       0
`define MRC_BIT_POR       1
`define MRC_BIT_SUP       2
`define MRC_BIT_SWR       3
`define MRC_BIT_MON_EN    0
`define MRC_BIT_SUPSEL    1

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define MRC_PORT_RESET    8'hff
`define MRC_PROG_CNT_RESET 16'h0000
`define MRC_SP_RESET      8'h07
`define MRC_WDT_DIV       4'hc
`define MRC_CLK_MHZ       250
`define MRC_POR_DELAY_NS  300000
`define MRC_POR_CYCLES    ((`MRC_POR_DELAY_NS * `MRC_CLK_MHZ) / 1000)
// cycles the own pin drive stays masked after release, covers synchroniser latency
`define MRC_PIN_ECHO_CYCLES 3'h5
`endif

// ### src/mrc_pkg.sv
package mrc_pkg;
	// sequencer states, one-hot
	typedef enum logic [3:0] {
		MRC_ST_HOLD  = 4'b0001,
		MRC_ST_DELAY = 4'b0010,
		MRC_ST_SYNC  = 4'b0100,
		MRC_ST_RUN   = 4'b1000
	} mrc_state_t;

	// reset values handed to the core
	typedef struct packed {
		logic        core_run;
		logic        irq_timer_en;
		logic [15:0] program_counter;
		logic [7:0]  stack_ptr;
		logic        clk_sel_internal;
		logic        wdt_en;
		logic [3:0]  wdt_div;
		logic [7:0]  port_latch;
		logic        port_open_drain;
		logic        weak_pullup_en;
	} mrc_core_ctl_t;
endpackage : mrc_pkg

// ### src/mrc_sync3.sv
`timescale 1ns/1ps
`include "mrc_params.svh"
// three-stage synchroniser, change taken when stages 2 and 3 agree
module mrc_sync3 #(
	parameter logic RST_VAL = 1'b1
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic en,
	input  wire logic din,
	output logic      dout
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	// shift chain
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
		end else if (en) begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// filtered output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dout <= RST_VAL;
		end else if (en && (s2_q == s3_q)) begin
			dout <= s3_q;
		end
	end
endmodule : mrc_sync3

// ### verif/mrc_pin_sup.sv
`timescale 1ns/1ps
// ----------------------------------------
// external supervisor on the reset pin
// ----------------------------------------
module mrc_pin_sup (
	input  wire logic pclk,
	input  wire logic trig,
	output logic      pull_low
);
	logic [3:0] cnt_q = 4'h0;

	// a trigger pulls the pin low for eight cycles
	always @(posedge pclk) begin
		if (trig)
			cnt_q <= 4'h8;
		else if (cnt_q != 4'h0)
			cnt_q <= cnt_q - 4'h1;
	end

	// open drain: only ever pulls low
	assign pull_low = (cnt_q != 4'h0);
endmodule : mrc_pin_sup

// ### verif/mrc_reset_ctrl_chk.sv
`timescale 1ns/1ps
// ----------------------------------------
// reset sequencing checks
// ----------------------------------------
module mrc_reset_ctrl_chk #(
	parameter int POR_CYCLES = 20
) (
	input wire logic                   pclk,
	input wire logic                   presetn,
	input wire logic                   rst_pin_oe_n,
	input wire logic                   sys_rst_n,
	input wire mrc_pkg::mrc_core_ctl_t core_ctl,
	input wire logic                   supply_mon_en
);
	int   cnt_q;
	logic por_q;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// cycles in the current reset, cleared on each release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 0;
			por_q <= 1'b1;
		end else if (sys_rst_n) begin
			cnt_q <= 0;
			por_q <= 1'b0;
		end else begin
			cnt_q <= cnt_q + 1;
		end
	end

	a_async_entry: assert property ($rose(presetn) |-> !rst_pin_oe_n && !sys_rst_n)
		else $error("reset not held after power-on");
	a_core_halted: assert property (!sys_rst_n |-> !core_ctl.core_run && !core_ctl.irq_timer_en)
		else $error("core or timers active in reset");
	a_port_state: assert property (!sys_rst_n |-> core_ctl.port_latch == 8'hff && core_ctl.port_open_drain)
		else $error("port latches not forced in reset");
	a_pullup_kept: assert property ($rose(sys_rst_n) |-> core_ctl.weak_pullup_en [*3])
		else $error("pull-ups dropped after release");
	a_exit_values: assert property ($rose(sys_rst_n) |-> core_ctl.program_counter == 16'h0000 && core_ctl.clk_sel_internal && core_ctl.stack_ptr == 8'h07)
		else $error("core defaults wrong at exit");
	a_watchdog_on: assert property ($rose(sys_rst_n) |-> core_ctl.wdt_en && core_ctl.wdt_div == 4'hc)
		else $error("watchdog not set at exit");
	a_por_delay: assert property ($rose(sys_rst_n) && por_q |-> cnt_q > POR_CYCLES)
		else $error("power-on release too early");
	a_pin_release: assert property (sys_rst_n && $past(sys_rst_n) |-> rst_pin_oe_n)
		else $error("pin driven while running");
	a_monitor_on: assert property ($rose(sys_rst_n) && por_q |-> supply_mon_en)
		else $error("monitor off after power-on");
endmodule : mrc_reset_ctrl_chk

bind mrc_reset_ctrl mrc_reset_ctrl_chk #(.POR_CYCLES(POR_CYCLES)) chk_inst (
	.pclk, .presetn, .rst_pin_oe_n, .sys_rst_n, .core_ctl, .supply_mon_en);

// ### verif/mrc_reset_ctrl_test.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
	$display("Error %0t got %h exp %h", $time, g, e); end end
// ----------------------------------------
// reset controller bench
// ----------------------------------------
module mrc_reset_ctrl_test;
	logic                   pclk = 1'b0;
	logic                   presetn = 1'b0;
	logic                   supply_good = 1'b0;
	logic                   supply_low = 1'b0;
	logic                   psel = 1'b0;
	logic                   penable = 1'b0;
	logic                   pwrite = 1'b0;
	logic                   trig = 1'b0;
	logic [11:0]            paddr = 12'h000;
	logic [31:0]            pwdata = 32'h0;
	logic [31:0]            prdata, r, m;
	logic [32:0]            e;
	logic                   rst_pin_out, rst_pin_oe_n, sys_rst_n, supply_mon_en;
	logic                   pready, pslverr, irq, pull_low, pin_w;
	mrc_pkg::mrc_core_ctl_t core_ctl;
	int                     n_errors = 0;
	int                     checked = 0;
	int                     seed = 32'h613b;
	logic [32:0]            eq[$];
	logic [31:0]            mq[$];

	always #2 pclk = ~pclk;

	// pin level: pull-up, device and supervisor both open drain
	assign pin_w = (rst_pin_oe_n ? 1'b1 : rst_pin_out) & ~pull_low;

	mrc_reset_ctrl #(.POR_CYCLES(20)) mrc_reset_ctrl_inst (
		.pclk, .presetn, .clk_en(1'b1), .supply_good, .supply_low,
		.rst_pin_in(pin_w), .rst_pin_out, .rst_pin_oe_n, .sys_rst_n, .core_ctl,
		.supply_mon_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .irq);

	mrc_pin_sup mrc_pin_sup_inst (.pclk, .trig, .pull_low);

	// compare each finished read with the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && eq.size() > 0) begin
			m = mq.pop_front();
			e = eq.pop_front();
			`CHK({pslverr, prdata & m}, e)
		end
	end

	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : xfer

	task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] k);
		eq.push_back({a > 12'h00c, x & k});
		mq.push_back(k);
		xfer(1'b0, a, 32'h0);
	endtask : rd

	task automatic wait_rst(input logic v);
		for (int i = 0; i < 400 && sys_rst_n !== v; i++) @(posedge pclk);
		`CHK(sys_rst_n, v)
	endtask : wait_rst

	task automatic conclude();
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude

	// watchdog against a hang
	initial begin
		repeat (3000) @(posedge pclk);
		n_errors++;
		conclude();
	end

	// main sequence
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (6) @(posedge pclk);
		supply_good <= 1'b1;
		wait_rst(1'b1);
		rd(12'h000, 32'h2, 32'h2);
		rd(12'h004, 32'h1, 32'h1);
		`CHK(supply_mon_en, 1'b1)
		xfer(1'b1, 12'h00c, 32'h2);
		`CHK(irq, 1'b1)
		rd(12'h008, 32'h2, 32'h2);
		`CHK(irq, 1'b0)
		r = $random(seed);
		xfer(1'b1, 12'h00c, r);
		rd(12'h00c, r, 32'h7);
		xfer(1'b1, 12'h004, 32'h0);
		rd(12'h004, 32'h0, 32'h1);
		xfer(1'b1, 12'h010, r);
		rd(12'h010, 32'h0, 32'hffffffff);
		// external supervisor pulls the pin
		trig <= 1'b1;
		@(posedge pclk);
		trig <= 1'b0;
		wait_rst(1'b0);
		`CHK(rst_pin_oe_n, 1'b1)
		wait_rst(1'b1);
		rd(12'h000, 32'h1, 32'h3);
		rd(12'h004, 32'h0, 32'h1);
		xfer(1'b1, 12'h00c, 32'h7);
		`CHK(irq, 1'b1)
		rd(12'h008, 32'h1, 32'h7);
		`CHK(irq, 1'b0)
		// supply monitor selected as reset source, then tripped
		xfer(1'b1, 12'h004, 32'h3);
		supply_low <= 1'b1;
		wait_rst(1'b0);
		`CHK(rst_pin_oe_n, 1'b0)
		supply_low <= 1'b0;
		wait_rst(1'b1);
		rd(12'h000, 32'h4, 32'h7);
		rd(12'h004, 32'h3, 32'h3);
		// supply falls below threshold and recovers
		supply_good <= 1'b0;
		wait_rst(1'b0);
		`CHK(rst_pin_oe_n, 1'b0)
		supply_good <= 1'b1;
		wait_rst(1'b1);
		rd(12'h000, 32'h2, 32'h7);
		rd(12'h004, 32'h1, 32'h3);
		// software forces a power-on reset
		xfer(1'b1, 12'h000, 32'h1);
		wait_rst(1'b0);
		repeat (2) @(posedge pclk);
		`CHK(rst_pin_oe_n, 1'b0)
		wait_rst(1'b1);
		rd(12'h000, 32'h2, 32'h2);
		rd(12'h004, 32'h1, 32'h1);
		conclude();
	end
endmodule : mrc_reset_ctrl_test
